// *** include/io_port_pkg.sv ***
package io_port_pkg;

  // Register byte offsets within a bus page
  localparam logic [3:0] ADDR_PIN_LEVEL = 4'h0;
  localparam logic [3:0] ADDR_PIN_DIRECTION = 4'h4;
  localparam logic [3:0] ADDR_OUTPUT_LATCH = 4'h8;
  localparam logic [3:0] ADDR_ANALOG_SELECT = 4'hc;
  localparam logic [3:0] ADDR_PULLUP_ENABLE = 4'h0;
  localparam logic [3:0] ADDR_PULLUP_PAGE = 4'h1;
  localparam logic [3:0] ADDR_OPTION = 4'h4;

  // Pin bit positions
  localparam int PIN0 = 0;
  localparam int PIN1 = 1;
  localparam int PIN3 = 3;
  localparam int PIN4 = 4;
  localparam int PIN5 = 5;

  // Implemented-bit masks
  localparam logic [7:0] PIN_MASK = 8'h3b;
  localparam logic [7:0] DIR_FIXED_ONES = 8'h0b;
  localparam logic [7:0] DIR_RW_MASK = 8'h30;
  localparam logic [7:0] LATCH_MASK = 8'h30;
  localparam logic [7:0] ANALOG_MASK = 8'h10;
  localparam logic [7:0] PULLUP_MASK = 8'h38;

  // Reset values
  localparam logic [1:0] DIR_RESET = 2'h3;
  localparam logic ANALOG_RESET = 1'b1;
  localparam logic [2:0] PULLUP_RESET = 3'h7;
  localparam logic OPTION_PULLUP_N_RESET = 1'b1;
  localparam int OPTION_PULLUP_N_BIT = 7;

  // Peripheral output requests for the two drivable pins
  typedef struct packed {
    logic sysclk_en;
    logic sysclk_out;
    logic secondary_osc_en;
    logic secondary_osc_out;
    logic reference_clock_en;
    logic reference_clock_out;
    logic serial_data_en;
    logic serial_data_out;
    logic pwm_channel2_en;
    logic pwm_channel2_out;
  } periph_out_s;

endpackage : io_port_pkg

// *** verification/five_bit_io_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module five_bit_io_port_tb_top;
  import io_port_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic reset_pin_enable_i = 1'b0;
  periph_out_s periph_i = '0;
  logic [7:0] pin_i, pin_o, pin_oe_o, pullup_on_o, digital_in_en_o, rd;
  logic [7:0] pad_ext = 8'hff;
  logic [9:0] src;
  int miscompares = 0;
  int num_checks = 0;
  int ticks = 0;
  always #12.5 clk_i = ~clk_i;
  five_bit_io_port i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .reset_pin_enable_i(reset_pin_enable_i), .periph_i(periph_i), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pullup_on_o(pullup_on_o), .digital_in_en_o(digital_in_en_o)
  );
  pad_model i_pad (
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_on_o(pullup_on_o), .pad_ext(pad_ext), .pin_i(pin_i)
  );
  ////////////////////////////////////////////////////////////////
  // Classic cycle: hold everything until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [4:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h0);
    chk(rd, exp);
  endtask : rc
  // Pads settle one cycle after ack, reads need two more for the synchroniser
  task automatic wt();
    repeat (3) @(posedge clk_i);
  endtask : wt
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rc(5'h04, 8'h3b);
    rc(5'h0c, 8'h10);
    rc(5'h10, 8'h38);
    rc(5'h1c, 8'h00);
    wb(1'b0, 5'h14, 8'h0);
    chk(rd & 8'h80, 8'h80);
    rc(5'h00, 8'h2b);
    chk(digital_in_en_o, 8'h2b);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    wb(1'b1, 5'h04, 8'h00);
    rc(5'h04, 8'h0b);
    wb(1'b1, 5'h00, 8'hff);
    rc(5'h08, 8'h30);
    wb_sel_i <= 4'h0;
    wb(1'b1, 5'h08, 8'h00);
    wb_sel_i <= 4'h1;
    rc(5'h08, 8'h30);
    wb(1'b1, 5'h08, 8'h10);
    wt();
    chk(pin_oe_o, 8'h30);
    chk(pin_o & 8'h30, 8'h10);
    rc(5'h00, 8'h0b);
    wb(1'b1, 5'h0c, 8'h00);
    wt();
    rc(5'h00, 8'h1b);
    rc(5'h0c, 8'h00);
    chk(digital_in_en_o, 8'h3b);
    $display("test regs done");
  endtask : t_regs
  task automatic t_prio();
    wb(1'b1, 5'h08, 8'h00);
    wb(1'b1, 5'h0c, 8'h10);
    for (int k = 0; k < 4; k++) begin
      src = 10'h0;
      for (int j = k; j < 4; j++) src[9 - 2 * j] = 1'b1;
      src[8 - 2 * k] = 1'b1;
      src[1:0] = {1'b1, k[0]};
      @(posedge clk_i);
      periph_i <= periph_out_s'(src);
      wt();
      chk(pin_o & 8'h30, {2'h0, k[0], 5'h10});
    end
    @(posedge clk_i);
    periph_i <= '0;
    wb(1'b1, 5'h04, 8'h30);
    wt();
    chk(pin_oe_o, 8'h00);
    $display("test prio done");
  endtask : t_prio
  task automatic t_pull();
    pad_ext <= 8'h00;
    wb(1'b1, 5'h14, 8'h00);
    wt();
    chk(pullup_on_o, 8'h38);
    rc(5'h00, 8'h28);
    wb(1'b1, 5'h04, 8'h00);
    wt();
    chk(pullup_on_o, 8'h08);
    wb(1'b1, 5'h14, 8'h80);
    wt();
    chk(pullup_on_o, 8'h00);
    reset_pin_enable_i <= 1'b1;
    wt();
    chk(pullup_on_o, 8'h08);
    rc(5'h10, 8'h38);
    $display("test pull done");
  endtask : t_pull
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // A hung handshake would stall forever, so a cycle ceiling ends the run
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_prio();
    t_pull();
    wrap_up();
  end
endmodule : five_bit_io_port_tb_top
bind five_bit_io_port io_port_properties i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_pin_enable_i(reset_pin_enable_i),
  .periph_i(periph_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_on_o(pullup_on_o),
  .digital_in_en_o(digital_in_en_o)
);
`default_nettype wire

// *** verification/io_port_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module io_port_properties
  import io_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic reset_pin_enable_i,
  input wire periph_out_s periph_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pullup_on_o,
  input wire logic [7:0] digital_in_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer timing; option byte is excluded because it holds more than the port bits
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_idle_dat: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  a_unimp_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0 && (wb_adr_i == 5'h14 ||
    (wb_dat_o[7:6] == 2'h0 && !wb_dat_o[2]))) else $error("unimplemented bit set");
  // Pad side
  a_oe_pins: assert property ((pin_oe_o & 8'hcf) == 8'h0) else $error("driver on input pin");
  a_pull_out: assert property ((pullup_on_o & pin_oe_o) == 8'h0) else $error("pull-up on output");
  a_pin3_force: assert property (!$past(rst_i) && $past(reset_pin_enable_i) |-> pullup_on_o[3]) else $error("pin3 pull");
  a_analog_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 5'h0 && !digital_in_en_o[4]
    |-> !wb_dat_o[4]) else $error("analog pin read one");
  a_pwm_wins: assert property (!$past(rst_i) && pin_oe_o[5] && $past(periph_i.pwm_channel2_en)
    |-> pin_o[5] == $past(periph_i.pwm_channel2_out)) else $error("pwm lost pin5");
  a_clk_wins: assert property (!$past(rst_i) && pin_oe_o[4] && $past(periph_i.sysclk_en)
    |-> pin_o[4] == $past(periph_i.sysclk_out)) else $error("clock out lost pin4");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_clk_drive: cover property (pin_oe_o[4] && periph_i.sysclk_en);
  c_pin3: cover property (pullup_on_o[3] && reset_pin_enable_i);
endmodule : io_port_properties
`default_nettype wire

// *** verification/pad_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pullup_on_o,
  input wire logic [7:0] pad_ext,
  output logic [7:0] pin_i
);
  // Own driver wins; an undriven pad rises through the pull-up, else follows the outside level
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & (pullup_on_o | pad_ext));
endmodule : pad_model
`default_nettype wire

// *** verilog/five_bit_io_port.sv ***
// Summary of operation
// - Five physical pins at bits 0, 1, 3, 4 and 5 of 8-bit registers.
// - Direction bit one turns the pin driver off, making an input.
// - Direction bit zero drives latch value unless a stronger peripheral owns pin.
// - Pins 0, 1, 3 are input only; their direction bits always read one.
// - Pin level reads actual pins; writes go into the output latch.
// - Port writes store written bits 5-4 in the latch; any merge is software read-modify-write.
// - Direction bits govern drivers even on analog pins.
// - Analog-selected pin reads zero digitally; its input buffer is off.
// - Analog select never changes digital output.
// - Analog select resets to analog; software clears it for digital input.
// - Several enabled sources on a pin: highest priority wins.
// - Pin 4: clock, sec osc, ref clock, serial data, latch; pin 5: pwm_channel2_out, latch.
// - Peripherals drive analog-mode pins in the same priority order.
// - Pin level has bits 5-3, 1-0; bits 7-6, 2 read zero; 3,1,0 read-only.
// - Direction bits 5-4 writable reset one; 3,1,0 fixed one; 7,6,2 zero.
// - Latch has bits 5-4 only, kept across resets; others read zero.
// - Analog select holds bit 4 only, reset one; others read zero.
// - Pull-up enable bits 5-3 reset one; set enables pull-up; others zero.
// - Pull-ups act only while global active-low pull-up disable bit is clear.
// - A pin configured as output has its pull-up disabled.
// - Reset-pin enable forces pin 3 pull-up on, not shown in register.
`timescale 1ns/1ps
`default_nettype none

module five_bit_io_port
  import io_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Configuration and peripherals
  input wire logic reset_pin_enable_i,
  input wire periph_out_s periph_i,
  // Pads: bits 0,1,3,4,5 used
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pullup_on_o,
  output logic [7:0] digital_in_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets on the bus, low byte of the data word only:
  //   0x00 pin level      read: synchronised pins, analog pin reads zero
  //                       write: bits 5-4 land in the output latch
  //   0x04 pin direction  bits 5-4 writable, bits 3, 1, 0 always one
  //   0x08 output latch   bits 5-4 only, no reset
  //   0x0c analog select  bit 4 only, resets to analog
  //   0x10 pull-up enable bits 5-3, reset to one
  //   0x14 option         bit 7 is the global active-low pull-up disable
  // Every other offset reads zero, ignores writes and still answers, so
  // software probing the map never hangs the bus.
  //
  // Pad side: pin_o, pin_oe_o and pullup_on_o drive the pad cells, and
  // digital_in_en_o gates the pad input buffer. All of them come from
  // flip-flops, so a register write shows at the pads one cycle after
  // its acknowledge.

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: stage one is read by stage two only
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;

  always_ff @(posedge clk_i) begin
    pin_meta_r <= pin_i;
    pin_sync_r <= pin_meta_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [1:0] dir_r;         // Bits 5-4
  logic [1:0] latch_r;       // Bits 5-4, no reset on purpose
  logic analog_sel_pin4_r;
  logic [2:0] pullup_r;      // Bits 5-3
  logic global_pullup_disable_n_r;

  // Bus decode; address bit 4 selects the second page
  logic wr_stb;
  logic rd_stb;
  logic [3:0] adr_lo;
  logic page_hi;
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign adr_lo = wb_adr_i[3:0];
  assign page_hi = wb_adr_i[4];

  logic sel_level, sel_dir, sel_latch, sel_analog, sel_pullup, sel_option;
  assign sel_level = !page_hi && adr_lo == ADDR_PIN_LEVEL;
  assign sel_dir = !page_hi && adr_lo == ADDR_PIN_DIRECTION;
  assign sel_latch = !page_hi && adr_lo == ADDR_OUTPUT_LATCH;
  assign sel_analog = !page_hi && adr_lo == ADDR_ANALOG_SELECT;
  assign sel_pullup = page_hi && adr_lo == ADDR_PULLUP_ENABLE;
  assign sel_option = page_hi && adr_lo == ADDR_OPTION;

  // Digital view of the pins: analog pin reads zero
  logic [7:0] analog_vec;
  logic [7:0] digital_view;
  assign analog_vec = {3'h0, analog_sel_pin4_r, 4'h0} & ANALOG_MASK;
  assign digital_view = pin_sync_r & PIN_MASK & ~analog_vec;

  // Direction: only bits 5-4 writable, reset to input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_r <= DIR_RESET;
    end else if (wr_stb && sel_dir) begin
      dir_r <= wb_dat_i[PIN5:PIN4];
    end
  end

  // Latch: a pin-level write is the merged byte of a read-modify-write, so
  // bits 5-4 of it are stored; other positions have no latch behind them
  // Software that reads an analog pin as zero and writes it back clears its
  // latch, which is the hazard of merging on analog pins
  always_ff @(posedge clk_i) begin
    if (wr_stb && sel_latch) begin
      latch_r <= wb_dat_i[PIN5:PIN4];
    end else if (wr_stb && sel_level) begin
      latch_r <= wb_dat_i[PIN5:PIN4];
    end
  end

  // Analog select resets to analog mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_sel_pin4_r <= ANALOG_RESET;
    end else if (wr_stb && sel_analog) begin
      analog_sel_pin4_r <= wb_dat_i[PIN4];
    end
  end

  // Pull-up enables and global active-low disable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pullup_r <= PULLUP_RESET;
    end else if (wr_stb && sel_pullup) begin
      pullup_r <= wb_dat_i[PIN5:PIN3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_pullup_disable_n_r <= OPTION_PULLUP_N_RESET;
    end else if (wr_stb && sel_option) begin
      global_pullup_disable_n_r <= wb_dat_i[OPTION_PULLUP_N_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and ack; unmapped addresses read zero and still ack
  logic [7:0] rd_data;
  always_comb begin
    rd_data = 8'h00;
    if (sel_level) begin
      rd_data = digital_view;
    end else if (sel_dir) begin
      rd_data = DIR_FIXED_ONES | ({2'h0, dir_r, 4'h0} & DIR_RW_MASK);
    end else if (sel_latch) begin
      rd_data = {2'h0, latch_r, 4'h0} & LATCH_MASK;
    end else if (sel_analog) begin
      rd_data = analog_vec;
    end else if (sel_pullup) begin
      rd_data = {2'h0, pullup_r, 3'h0} & PULLUP_MASK;
    end else if (sel_option) begin
      rd_data = {global_pullup_disable_n_r, 7'h00};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= rd_stb;
      wb_dat_o <= rd_stb ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output priority; analog select plays no part here
  logic pin4_val;
  logic pin5_val;
  always_comb begin
    if (periph_i.sysclk_en) begin
      pin4_val = periph_i.sysclk_out;
    end else if (periph_i.secondary_osc_en) begin
      pin4_val = periph_i.secondary_osc_out;
    end else if (periph_i.reference_clock_en) begin
      pin4_val = periph_i.reference_clock_out;
    end else if (periph_i.serial_data_en) begin
      pin4_val = periph_i.serial_data_out;
    end else begin
      pin4_val = latch_r[0];
    end
    pin5_val = periph_i.pwm_channel2_en ? periph_i.pwm_channel2_out : latch_r[1];
  end

  // Drivers follow direction only, also for analog pins (limitation: a
  // peripheral cannot drive a pin left as input)
  logic [7:0] oe_nxt;
  logic [7:0] pu_nxt;
  assign oe_nxt = {2'h0, ~dir_r, 4'h0};
  always_comb begin
    pu_nxt = 8'h00;
    if (!global_pullup_disable_n_r) begin
      pu_nxt = {2'h0, pullup_r, 3'h0} & ~oe_nxt;
    end
    if (reset_pin_enable_i) begin
      pu_nxt[PIN3] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered pad controls, one flip-flop group per concern

  // Drive value: only pins 5 and 4 have a driver behind them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 8'h00;
    end else begin
      pin_o <= {2'h0, pin5_val, pin4_val, 4'h0};
    end
  end

  // Driver enable: low through reset so no pad fights the board at power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_oe_o <= 8'h00;
    end else begin
      pin_oe_o <= oe_nxt;
    end
  end

  // Pull-ups: global disable resets high, so they start off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pullup_on_o <= 8'h00;
    end else begin
      pullup_on_o <= pu_nxt;
    end
  end

  // Input buffer gate: off for the analog pin to save crowbar current
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      digital_in_en_o <= 8'h00;
    end else begin
      digital_in_en_o <= PIN_MASK & ~analog_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: the slices and masks above assume this layout

  // The latch and direction slices take two adjacent bits
  if (PIN5 != PIN4 + 1) begin : g_bad_pin_pair
    $error("Pins 5 and 4 must be adjacent bits");
  end

  // The pull-up slice spans pins 5 down to 3
  if (PIN4 != PIN3 + 1) begin : g_bad_pull_span
    $error("Pins 4 and 3 must be adjacent bits");
  end

  // Fixed and writable direction bits must not overlap
  if ((DIR_FIXED_ONES & DIR_RW_MASK) != 8'h00) begin : g_bad_dir_masks
    $error("Direction masks overlap");
  end

  // Only drivable pins may carry a latch
  if (LATCH_MASK != DIR_RW_MASK) begin : g_bad_latch_mask
    $error("Latch mask must match the writable direction bits");
  end

  // The analog pin must be one of the port pins
  if ((ANALOG_MASK & ~PIN_MASK) != 8'h00) begin : g_bad_analog_mask
    $error("Analog mask outside the port pins");
  end

  // Pull-ups only where a pin exists
  if ((PULLUP_MASK & ~PIN_MASK) != 8'h00) begin : g_bad_pull_mask
    $error("Pull-up mask outside the port pins");
  end

  // The option bit must sit in the low data byte
  if (OPTION_PULLUP_N_BIT > 7) begin : g_bad_option_bit
    $error("Option bit outside the data byte");
  end

  // The pull-up and option registers share the second page
  if (ADDR_PULLUP_ENABLE == ADDR_OPTION) begin : g_bad_page_map
    $error("Pull-up and option offsets collide");
  end

endmodule : five_bit_io_port

`default_nettype wire
